/* File: hdl/mpcg_pkg.sv */
// Purpose : shared constants and types for the master and peripheral clock gating block
// Assumes : clock sources arrive as one-cycle ticks synchronous to ref_clk
// Notes   : master and gated clocks leave the block as one-cycle enable ticks
package mpcg_pkg;

   // ------------------------------------------------------------------
   // register offsets (byte addresses)
   // ------------------------------------------------------------------
   localparam logic [7:0] OFS_SYS_EN    = 8'h00;
   localparam logic [7:0] OFS_SYS_DIS   = 8'h04;
   localparam logic [7:0] OFS_SYS_STATE = 8'h08;
   localparam logic [7:0] OFS_PER_EN_A  = 8'h10;
   localparam logic [7:0] OFS_PER_DIS_A = 8'h14;
   localparam logic [7:0] OFS_PER_ST_A  = 8'h18;
   localparam logic [7:0] OFS_PER_EN_B  = 8'h20;
   localparam logic [7:0] OFS_PER_DIS_B = 8'h24;
   localparam logic [7:0] OFS_PER_ST_B  = 8'h28;
   localparam logic [7:0] OFS_MCK_CFG   = 8'h30;
   localparam logic [7:0] OFS_USB_CLK   = 8'h34;
   localparam logic [7:0] OFS_PWR_STAT  = 8'h38;
   localparam logic [7:0] OFS_SLOW_SEL  = 8'h3c;
   localparam logic [7:0] OFS_FAST_WAKE = 8'h40;
   localparam logic [7:0] OFS_TICK_CAL  = 8'h44;

   // ------------------------------------------------------------------
   // field positions
   // ------------------------------------------------------------------
   localparam int SYS_COP_CORE  = 0;   // coprocessor gated clock
   localparam int SYS_COP_BRIDGE = 1;  // coprocessor bus bridge clock
   localparam int SYS_USB_PORT  = 6;   // usb_port_clk_bit
   localparam int CFG_SRC_LSB   = 0;   // src_select_field [1:0]
   localparam int CFG_DIV_LSB   = 4;   // master_div_field [6:4]
   localparam int CFG_CSRC_LSB  = 16;  // cop_src_select_field [17:16]
   localparam int CFG_CDIV_LSB  = 20;  // cop_div_field [22:20]
   localparam int USB_PLL_SEL   = 0;   // pll feeding the usb clock
   localparam int USB_FIXED_ONE = 4;   // must be written as one
   localparam int USB_DIV_LSB   = 8;   // usb_pll_divider [11:8]
   localparam int STAT_PLL_LOCK = 1;
   localparam int STAT_MCK_OK   = 3;   // master_clk_ok_flag
   localparam int FW_DEEP_LP    = 20;  // deep_low_power_sel

   // ------------------------------------------------------------------
   // reset values and fixed values
   // ------------------------------------------------------------------
   localparam logic [31:0] CFG_RST      = 32'h0000_0001; // system master from main clock, coprocessor master from slow clock, both divide by 1
   localparam logic [31:0] USB_RST      = 32'h0000_0000;
   localparam logic [15:0] TICK_CAL_VAL = 16'h1f40;      // 8000 counts per 1 ms
   localparam logic [2:0]  DIV_BY_THREE = 3'h7;

   // ------------------------------------------------------------------
   // types
   // ------------------------------------------------------------------
   typedef enum logic [1:0] {
      CORE_RUN   = 2'b00,
      CORE_DRAIN = 2'b01,
      CORE_SLEEP = 2'b11
   } mpcg_core_st_t;

   typedef struct packed {
      logic        cyc;
      logic        stb;
      logic        we;
      logic [7:0]  adr;
      logic [3:0]  sel;
      logic [31:0] dat;
   } mpcg_wb_req_t;

   typedef struct packed {
      logic        ack;
      logic [31:0] dat;
   } mpcg_wb_rsp_t;

   typedef struct packed {
      logic slow_tick;
      logic main_tick;
      logic plla_tick;
      logic pllb_tick;
   } mpcg_src_t;

   typedef struct packed {
      logic wait_irq_instr;     // wait_irq_instr decoded
      logic wait_event_instr;     // wait_event_instr decoded
      logic retire;  // current instruction has completed
      logic wake;    // any enabled fast or normal interrupt
   } mpcg_core_t;

endpackage

/* File: hdl/mpcg_div.sv */
// Purpose : prescaler for one master clock, divide by 1..64 in powers of two or by 3
// Assumes : src_tick is a one-cycle tick of the selected source
// Notes   : settled pulses with the first output tick after restart
`timescale 1ns/10ps
module mpcg_div (
   // clock and reset
   input  wire logic       ref_clk,
   input  wire logic       reset_n,
   // source and setting
   input  wire logic       src_tick,
   input  wire logic [2:0] div_code,
   input  wire logic       restart,
   // divided output
   output logic            tick,
   output logic            settled
);
   import mpcg_pkg::*;

   typedef struct packed {
      logic [5:0] cnt;
      logic       armed;
      logic       tick;
      logic       settled;
   } mpcg_div_st_t;

   mpcg_div_st_t st;
   mpcg_div_st_t next_st;
   logic [5:0]   limit;

   // terminal count for the chosen ratio
   always_comb begin
      if (div_code == DIV_BY_THREE) begin
         limit = 6'h02;
      end else begin
         limit = 6'((7'h01 << div_code) - 7'h01);
      end
   end

   // count source ticks, emit one tick per ratio
   always_comb begin
      next_st         = st;
      next_st.tick    = 1'b0;
      next_st.settled = 1'b0;
      if (restart) begin
         next_st.cnt   = 6'h00;
         next_st.armed = 1'b1;
      end else if (src_tick) begin
         if (st.cnt >= limit) begin
            next_st.cnt     = 6'h00;
            next_st.tick    = 1'b1;
            next_st.settled = st.armed;
            next_st.armed   = 1'b0;
         end else begin
            next_st.cnt = st.cnt + 6'h01;
         end
      end
   end

   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign tick    = st.tick;
   assign settled = st.settled;

   // divide by three never gives two ticks within three cycles
   div_three_gap_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
      (st.tick && div_code == DIV_BY_THREE && !restart && $stable(div_code))
         |=> !st.tick [*2])
      else $error("divide by three ticked too early");

endmodule // mpcg_div

/* File: hdl/mpcg_top.sv */
// Purpose : master clock select and divide, core sleep gating, usb and peripheral gating
// Assumes : classic Wishbone slave, one clock, all inputs synchronous to ref_clk
// Notes   : every clock output is a one-cycle enable tick on ref_clk
// Summary of operation
// - master clock source select, divide 1..64 or 3
// - two master clocks, one per subsystem
// - config write clears ready flag until settled
// - sleep instruction stops core clock if not deep
// - main core runs after reset, wakes on interrupt
// - coprocessor clock off at reset, software enables
// - core clock stops before current instruction completes
// - fixed tick calibration value 8000
// - usb port clock set, cleared, status shown
// - usb ports get 48 MHz and peripheral clock
// - two peripheral banks enable, disable, status
// - disable stops clock at once, all off
// - bit position equals peripheral identifier
// - free running core clocks continue in sleep
// - system master clock from main clock after startup, coprocessor master clock from slow clock
// - one slow oscillator selected, other off
//
// The register offsets and register access over Wishbone were left to the implementer.
`timescale 1ns/10ps
module mpcg_top (
   // clock and reset
   input  wire logic                   ref_clk,
   input  wire logic                   reset_n,
   // register bus
   input  wire mpcg_pkg::mpcg_wb_req_t wb_req,
   output mpcg_pkg::mpcg_wb_rsp_t      wb_rsp,
   // clock sources
   input  wire mpcg_pkg::mpcg_src_t    src,
   input  wire logic                   usb48_tick,
   input  wire logic                   pll_lock,
   // cores
   input  wire mpcg_pkg::mpcg_core_t   core_main,
   input  wire mpcg_pkg::mpcg_core_t   core_cop,
   // master and core clocks
   output logic                        sys_master_clk,
   output logic                        cop_master_clk,
   output logic                        core_freerun_clk,
   output logic                        cop_freerun_clk,
   output logic                        core_gated_clk,
   output logic                        cop_gated_clk,
   output logic [15:0]                 tick_calib,
   // gated clocks
   output logic                        usb_port_clk,
   output logic                        cop_bus_bridge_clk,
   output logic [31:0]                 periph_clk_a,
   output logic [31:0]                 periph_clk_b,
   // slow oscillator enables
   output logic                        rc32_osc_en,
   output logic                        xtal32_osc_en
);
   import mpcg_pkg::*;

   // ------------------------------------------------------------------
   // state
   // ------------------------------------------------------------------
   typedef struct packed {
      logic          ack;
      logic [31:0]   rdata;
      logic [31:0]   sys_en;
      logic [31:0]   per_a;
      logic [31:0]   per_b;
      logic [31:0]   cfg;
      logic [31:0]   usb;
      logic          slow_xtal;
      logic          deep_lp;
      logic          mck_ok;
      logic          sys_done;
      logic          cop_done;
      mpcg_core_st_t main_st;
      mpcg_core_st_t cop_st;
   } mpcg_state_t;

   mpcg_state_t st;
   mpcg_state_t next_st;

   logic        acc;       // access completes at this edge
   logic        wr;
   logic [31:0] wmask;
   logic [31:0] wbits;
   logic        cfg_wr;
   logic        sys_tick;
   logic        cop_tick;
   logic        sys_settled;
   logic        cop_settled;
   logic        sys_src_tick;
   logic        cop_src_tick;

   // ------------------------------------------------------------------
   // helpers
   // ------------------------------------------------------------------

   // select one of the four source ticks
   function automatic logic pick_src(input mpcg_src_t s, input logic [1:0] code);
      logic r;
      r = 1'b0;
      unique case (code)
         2'h0: r = s.slow_tick;
         2'h1: r = s.main_tick;
         2'h2: r = s.plla_tick;
         2'h3: r = s.pllb_tick;
      endcase
      return r;
   endfunction

   // one sleep step for a core
   function automatic mpcg_core_st_t core_step(input mpcg_core_st_t cur,
                                               input mpcg_core_t     c,
                                               input logic           deep);
      mpcg_core_st_t n;
      n = cur;
      unique case (cur)
         CORE_RUN: begin
            if ((c.wait_irq_instr || c.wait_event_instr) && !deep) begin
               n = c.retire ? CORE_SLEEP : CORE_DRAIN;
            end
         end
         CORE_DRAIN: begin
            if (c.retire) begin
               n = CORE_SLEEP;
            end
         end
         CORE_SLEEP: begin
            if (c.wake) begin
               n = CORE_RUN;
            end
         end
         default: n = CORE_RUN;
      endcase
      return n;
   endfunction

   // ------------------------------------------------------------------
   // bus decode
   // ------------------------------------------------------------------

   // byte lanes expanded to a bit mask, writes land on the ack edge
   always_comb begin
      acc    = st.ack && wb_req.cyc && wb_req.stb;
      wr     = acc && wb_req.we;
      wmask  = {{8{wb_req.sel[3]}}, {8{wb_req.sel[2]}}, {8{wb_req.sel[1]}}, {8{wb_req.sel[0]}}};
      wbits  = wb_req.dat & wmask;
      cfg_wr = wr && (wb_req.adr == OFS_MCK_CFG);
   end

   // ------------------------------------------------------------------
   // master clock dividers
   // ------------------------------------------------------------------

   // each subsystem picks its own source
   always_comb begin
      sys_src_tick = pick_src(src, st.cfg[CFG_SRC_LSB +: 2]);
      cop_src_tick = pick_src(src, st.cfg[CFG_CSRC_LSB +: 2]);
   end

   mpcg_div u_sys_div (
      .ref_clk  (ref_clk),
      .reset_n  (reset_n),
      .src_tick (sys_src_tick),
      .div_code (st.cfg[CFG_DIV_LSB +: 3]),
      .restart  (cfg_wr),
      .tick     (sys_tick),
      .settled  (sys_settled)
   );

   mpcg_div u_cop_div (
      .ref_clk  (ref_clk),
      .reset_n  (reset_n),
      .src_tick (cop_src_tick),
      .div_code (st.cfg[CFG_CDIV_LSB +: 3]),
      .restart  (cfg_wr),
      .tick     (cop_tick),
      .settled  (cop_settled)
   );

   // ------------------------------------------------------------------
   // next state
   // ------------------------------------------------------------------
   always_comb begin
      next_st     = st;
      next_st.ack = wb_req.cyc && wb_req.stb && !st.ack;

      // read data captured as ack rises
      if (wb_req.cyc && wb_req.stb && !st.ack && !wb_req.we) begin
         unique case (wb_req.adr)
            OFS_SYS_STATE: next_st.rdata = st.sys_en;
            OFS_PER_ST_A:  next_st.rdata = st.per_a;
            OFS_PER_ST_B:  next_st.rdata = st.per_b;
            OFS_MCK_CFG:   next_st.rdata = st.cfg;
            OFS_USB_CLK:   next_st.rdata = st.usb;
            OFS_PWR_STAT:  next_st.rdata = (32'(st.mck_ok) << STAT_MCK_OK)
                                           | (32'(pll_lock) << STAT_PLL_LOCK);
            OFS_SLOW_SEL:  next_st.rdata = {31'h0000_0000, st.slow_xtal};
            OFS_FAST_WAKE: next_st.rdata = 32'(st.deep_lp) << FW_DEEP_LP;
            OFS_TICK_CAL:  next_st.rdata = {16'h0000, TICK_CAL_VAL};
            default:       next_st.rdata = 32'h0000_0000;
         endcase
      end

      // sleep sequencing for both cores
      next_st.main_st = core_step(st.main_st, core_main, st.deep_lp);
      if (st.sys_en[SYS_COP_CORE]) begin
         next_st.cop_st = core_step(st.cop_st, core_cop, st.deep_lp);
      end

      // set and clear registers act only on bits written as one
      if (wr) begin
         unique case (wb_req.adr)
            OFS_SYS_EN: begin
               next_st.sys_en = st.sys_en | wbits;
               if (wbits[SYS_COP_CORE]) begin
                  next_st.cop_st = CORE_RUN;
               end
            end
            OFS_SYS_DIS: begin
               next_st.sys_en = st.sys_en & ~wbits;
               if (wbits[SYS_COP_CORE]) begin
                  next_st.cop_st = CORE_SLEEP;
               end
            end
            OFS_PER_EN_A:  next_st.per_a = st.per_a | wbits;
            OFS_PER_DIS_A: next_st.per_a = st.per_a & ~wbits;
            OFS_PER_EN_B:  next_st.per_b = st.per_b | wbits;
            OFS_PER_DIS_B: next_st.per_b = st.per_b & ~wbits;
            OFS_MCK_CFG: begin
               next_st.cfg      = (st.cfg & ~wmask) | wbits;
               next_st.mck_ok   = 1'b0;
               next_st.sys_done = 1'b0;
               next_st.cop_done = 1'b0;
            end
            OFS_USB_CLK:   next_st.usb = (st.usb & ~wmask) | wbits;
            OFS_SLOW_SEL: begin
               if (wb_req.sel[0]) begin
                  next_st.slow_xtal = wb_req.dat[0];
               end
            end
            OFS_FAST_WAKE: begin
               if (wb_req.sel[FW_DEEP_LP / 8]) begin
                  next_st.deep_lp = wb_req.dat[FW_DEEP_LP];
               end
            end
            default: begin
            end
         endcase
      end

      // ready flag follows the first tick of each new divider setting
      if (!cfg_wr) begin
         if (sys_settled) begin
            next_st.sys_done = 1'b1;
         end
         if (cop_settled) begin
            next_st.cop_done = 1'b1;
         end
         if ((st.sys_done || sys_settled) && (st.cop_done || cop_settled)) begin
            next_st.mck_ok = 1'b1;
         end
      end
   end

   // register the whole state
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         st          <= '0;
         st.cfg      <= CFG_RST;
         st.usb      <= USB_RST;
         st.mck_ok   <= 1'b1;
         st.sys_done <= 1'b1;
         st.cop_done <= 1'b1;
         st.main_st  <= CORE_RUN;
         st.cop_st   <= CORE_SLEEP;
      end else begin
         st <= next_st;
      end
   end

   // ------------------------------------------------------------------
   // outputs
   // ------------------------------------------------------------------

   // bus answer
   assign wb_rsp = '{ack: st.ack,
                     dat: st.rdata};

   // master and core clock ticks
   assign sys_master_clk   = sys_tick;
   assign cop_master_clk   = cop_tick;
   assign core_freerun_clk = sys_tick;
   assign cop_freerun_clk  = cop_tick;
   assign core_gated_clk   = sys_tick && (st.main_st == CORE_RUN);
   assign cop_gated_clk    = cop_tick && (st.cop_st == CORE_RUN)
                             && st.sys_en[SYS_COP_CORE];
   assign tick_calib       = TICK_CAL_VAL;

   // gated clocks, bank a on subsystem 0, bank b on subsystem 1
   assign usb_port_clk       = usb48_tick && st.sys_en[SYS_USB_PORT];
   assign cop_bus_bridge_clk = cop_tick && st.sys_en[SYS_COP_BRIDGE];
   assign periph_clk_a       = {32{sys_tick}} & st.per_a;
   assign periph_clk_b       = {32{cop_tick}} & st.per_b;

   // exactly one slow oscillator runs
   assign rc32_osc_en   = !st.slow_xtal;
   assign xtal32_osc_en = st.slow_xtal;

   // ------------------------------------------------------------------
   // checks
   // ------------------------------------------------------------------
   ack_one_cycle_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
      st.ack |=> !st.ack)
      else $error("ack held for more than one cycle");

   cfg_clears_ok_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
      cfg_wr |=> !st.mck_ok ##1 !st.mck_ok)
      else $error("ready flag not cleared by config write");

   per_disable_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
      (wr && wb_req.adr == OFS_PER_DIS_A) |=> ((st.per_a & $past(wbits)) == 32'h0000_0000)
         && ((periph_clk_a & $past(wbits)) == 32'h0000_0000))
      else $error("disabled peripheral clock still running");

   zero_bits_keep_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
      (wr && wb_req.adr == OFS_PER_EN_B)
         |=> ((st.per_b & ~$past(wbits)) == ($past(st.per_b) & ~$past(wbits))))
      else $error("zero bit changed a peripheral clock");

   sleep_entry_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
      (st.main_st == CORE_RUN && core_main.wait_irq_instr && !st.deep_lp && !core_main.retire)
         |=> st.main_st == CORE_DRAIN && !core_gated_clk)
      else $error("core clock not stopped on sleep instruction");

   wake_restart_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
      (st.main_st == CORE_SLEEP && core_main.wake) |=> st.main_st == CORE_RUN)
      else $error("main core did not wake on interrupt");

   freerun_sleep_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
      (st.main_st == CORE_SLEEP) |-> !core_gated_clk && core_freerun_clk == sys_master_clk)
      else $error("free running clock gated in sleep");

   tick_cal_read_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
      (acc && !wb_req.we && wb_req.adr == OFS_TICK_CAL) |-> wb_rsp.dat == 32'h0000_1f40)
      else $error("tick calibration read wrong");

   usb_gate_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
      (wr && wb_req.adr == OFS_SYS_DIS && wbits[SYS_USB_PORT]) |=> !usb_port_clk [*2])
      else $error("usb port clock running after disable");

   slow_one_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
      rc32_osc_en != xtal32_osc_en)
      else $error("slow oscillator enables not exclusive");

endmodule // mpcg_top

/* File: testbench/mpcg_core_model.sv */
// Purpose : core model that issues sleep instructions and counts gated ticks
// Assumes : bench commands are one-cycle pulses after a rising edge
// Notes   : retire follows the sleep instruction after lag cycles
`timescale 1ns/10ps
module mpcg_core_model (
   // clock and reset
   input  wire logic     ref_clk,
   input  wire logic     reset_n,
   // bench commands
   input  wire logic     sleep_cmd,
   input  wire logic     wake_cmd,
   input  wire logic     use_wfe,
   input  wire logic [3:0] lag,
   // block side
   input  wire logic     gated_clk,
   output mpcg_pkg::mpcg_core_t core,
   output int            runs
);
   import mpcg_pkg::*;
   int left;
   // issue the instruction, retire it lag cycles later, count gated ticks
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         core <= '0;
         left <= -1;
         runs <= 0;
      end else begin
         core.wait_irq_instr <= sleep_cmd & ~use_wfe;
         core.wait_event_instr <= sleep_cmd & use_wfe;
         core.wake <= wake_cmd;
         core.retire <= (sleep_cmd && lag == 4'h0) || left == 1;
         left <= sleep_cmd ? int'(lag) : (left > 0 ? left - 1 : -1);
         runs <= runs + int'(gated_clk);
      end
   end
endmodule // mpcg_core_model

/* File: testbench/test_mpcg_top.sv */
// Purpose : self-checking bench for the clock gating block
// Assumes : source ticks come from a free cycle counter
// Notes   : each scenario task drives the block and judges the result
`timescale 1ns/10ps
module test_mpcg_top;
   import mpcg_pkg::*;
   logic         ref_clk = 0, reset_n = 0, usb48_tick = 0, pll_lock = 0, src_on = 1;
   logic         m_sleep = 0, c_sleep = 0, wake = 0, use_wfe = 0;
   logic         sm, cm, fm, fc, gm, gc, usb, brg, rc, xt;
   logic [3:0]   lag = 4'h2;
   logic [15:0]  cal;
   logic [31:0]  pa, pb, q;
   mpcg_wb_req_t wb_req = '0;
   mpcg_wb_rsp_t wb_rsp;
   mpcg_src_t    src = '0;
   mpcg_core_t   core_main, core_cop;
   int           n_fail = 0, num_checks = 0, cyc = 0, runs_m, runs_c, n;
   wire [7:0]    probe = {sm, cm, fm, fc, gm, gc, usb, brg};
   // clock, timeout and source tick patterns (slow 1/8, main 1/1, plla 1/2, pllb 1/4)
   always #2.5 ref_clk = ~ref_clk;
   always @(posedge ref_clk) begin
      cyc <= cyc + 1;
      src <= src_on ? {cyc[2:0] == 3'h0, 1'b1, cyc[0], cyc[1:0] == 2'h0} : 4'h0;
      usb48_tick <= cyc[1:0] == 2'h2;
      if (cyc == 20000) begin
         n_fail++;
         finish_test();
      end
   end
   mpcg_top u_mpcg_top (.ref_clk, .reset_n, .wb_req, .wb_rsp, .src, .usb48_tick,
      .pll_lock, .core_main, .core_cop, .sys_master_clk(sm), .cop_master_clk(cm),
      .core_freerun_clk(fm), .cop_freerun_clk(fc), .core_gated_clk(gm),
      .cop_gated_clk(gc), .tick_calib(cal), .usb_port_clk(usb), .cop_bus_bridge_clk(brg),
      .periph_clk_a(pa), .periph_clk_b(pb), .rc32_osc_en(rc), .xtal32_osc_en(xt));
   mpcg_core_model u_mpcg_core_model (.ref_clk, .reset_n, .sleep_cmd(m_sleep),
      .wake_cmd(wake), .use_wfe, .lag, .gated_clk(gm), .core(core_main), .runs(runs_m));
   mpcg_core_model u_mpcg_core_model_cop (.ref_clk, .reset_n, .sleep_cmd(c_sleep),
      .wake_cmd(wake), .use_wfe, .lag, .gated_clk(gc), .core(core_cop), .runs(runs_c));
   task chk(input string w, input logic [31:0] e, input logic [31:0] g);
      num_checks++;
      if (g !== e) begin
         n_fail++;
         $display("unexpected %s: expected %h, seen %h", w, e, g);
      end
   endtask
   // classic single cycle, held until ack is sampled high
   task bus(input logic we, input logic [7:0] a, input logic [31:0] d);
      wb_req <= '{1'b1, 1'b1, we, a, 4'hf, d};
      do begin
         @(posedge ref_clk);
      end while (wb_rsp.ack !== 1'b1);
      q = wb_rsp.dat;
      wb_req <= '0;
      @(posedge ref_clk);
   endtask
   task rd(input string w, input logic [7:0] a, input logic [31:0] e);
      bus(1'b0, a, 32'h0);
      chk(w, e, q);
   endtask
   // count ticks of one probe bit, optionally starting right after a tick
   task ticks(input int i, input int len, input bit align);
      int k;
      k = 0;
      n = 0;
      while (align && probe[i] !== 1'b1 && k < 300) begin
         @(posedge ref_clk);
         k++;
      end
      repeat (len) begin
         @(posedge ref_clk);
         n += int'(probe[i] === 1'b1);
      end
   endtask
   task nap(input logic cop, input logic wait_event_instr);
      use_wfe <= wait_event_instr;
      if (cop) c_sleep <= 1'b1;
      else m_sleep <= 1'b1;
      @(posedge ref_clk);
      m_sleep <= 1'b0;
      c_sleep <= 1'b0;
      repeat (8) @(posedge ref_clk);
   endtask
   task rouse();
      wake <= 1'b1;
      @(posedge ref_clk);
      wake <= 1'b0;
      repeat (3) @(posedge ref_clk);
   endtask
   task t_reset();
      bus(1'b1, OFS_TICK_CAL, 32'h0);
      rd("cal reg", OFS_TICK_CAL, 32'h1f40);
      chk("cal out", 32'h1f40, {16'h0, cal});
      rd("cfg", OFS_MCK_CFG, 32'h1);
      rd("bank a", OFS_PER_ST_A, 32'h0);
      rd("bank b", OFS_PER_ST_B, 32'h0);
      rd("sys st", OFS_SYS_STATE, 32'h0);
      rd("unmapped", 8'hfc, 32'h0);
      chk("slow osc", 32'h1, {30'h0, xt, rc});
      ticks(2, 64, 0);
      chk("cop gated", 0, n);
      chk("cop runs", 0, runs_c);
      ticks(3, 64, 0);
      chk("main gated", 64, n);
      $display("reset test done");
   endtask
   task t_div();
      int ex[4];
      ex = '{24, 192, 96, 48};
      for (int s = 0; s < 4; s++) begin
         bus(1'b1, OFS_MCK_CFG, 32'(s) | (32'(s) << 16));
         ticks(7, 192, 1);
         chk("src rate", ex[s], n);
         ticks(6, 192, 1);
         chk("cop src rate", ex[s], n);
      end
      for (int d = 0; d < 8; d++) begin
         bus(1'b1, OFS_MCK_CFG, 32'h0001_0001 | (32'(d) << 4));
         ticks(7, 192, 1);
         chk("div rate", d == 7 ? 64 : 192 >> d, n);
         ticks(5, 192, 1);
         chk("free rate", d == 7 ? 64 : 192 >> d, n);
      end
      bus(1'b1, OFS_MCK_CFG, 32'h0071_0001);
      ticks(6, 192, 1);
      chk("cop by 3", 64, n);
      ticks(7, 192, 1);
      chk("main by 1", 192, n);
      $display("divider test done");
   endtask
   task t_ready();
      src_on <= 1'b0;
      bus(1'b1, OFS_MCK_CFG, CFG_RST);
      bus(1'b0, OFS_PWR_STAT, 32'h0);
      chk("ready low", 0, q[STAT_MCK_OK]);
      src_on <= 1'b1;
      repeat (20) @(posedge ref_clk);
      bus(1'b0, OFS_PWR_STAT, 32'h0);
      chk("ready high", 2, {q[STAT_MCK_OK], q[STAT_PLL_LOCK]});
      $display("ready test done");
   endtask
   task t_periph();
      bus(1'b1, OFS_SYS_EN, 32'h2);
      bus(1'b1, OFS_PER_EN_A, 32'h8000_0005);
      bus(1'b1, OFS_PER_EN_B, 32'h0000_0102);
      bus(1'b1, OFS_PER_DIS_A, 32'h0000_0001);
      bus(1'b1, OFS_PER_ST_A, 32'hffff_ffff);
      rd("bank a", OFS_PER_ST_A, 32'h8000_0004);
      rd("bank b", OFS_PER_ST_B, 32'h0000_0102);
      chk("clk a", 32'h8000_0004, pa);
      q = 0;
      repeat (16) begin
         @(posedge ref_clk);
         q |= pb;
      end
      chk("clk b", 32'h0000_0102, q);
      ticks(0, 64, 0);
      chk("bridge", 8, n);
      bus(1'b1, OFS_PER_DIS_A, 32'h8000_0004);
      chk("clk a off", 0, pa);
      $display("peripheral test done");
   endtask
   task t_usb();
      bus(1'b1, OFS_USB_CLK, 32'h10);
      rd("usb cfg", OFS_USB_CLK, 32'h10);
      pll_lock <= 1'b1;
      bus(1'b0, OFS_PWR_STAT, 32'h0);
      chk("pll lock", 1, q[STAT_PLL_LOCK]);
      bus(1'b1, OFS_SYS_EN, 32'h40);
      rd("usb on", OFS_SYS_STATE, 32'h42);
      ticks(1, 64, 0);
      chk("usb ticks", 16, n);
      bus(1'b1, OFS_SYS_DIS, 32'h40);
      rd("usb off", OFS_SYS_STATE, 32'h2);
      ticks(1, 64, 0);
      chk("usb idle", 0, n);
      $display("usb test done");
   endtask
   task t_sleep();
      nap(1'b0, 1'b0);
      q = runs_m;
      ticks(3, 32, 0);
      chk("main asleep", 0, n);
      chk("main runs", q, runs_m);
      ticks(5, 32, 0);
      chk("free run", 32, n);
      rouse();
      ticks(3, 32, 0);
      chk("main woken", 32, n);
      bus(1'b1, OFS_FAST_WAKE, 32'h0010_0000);
      lag <= 4'h0;
      nap(1'b0, 1'b1);
      ticks(3, 32, 0);
      chk("deep mode", 32, n);
      bus(1'b1, OFS_FAST_WAKE, 32'h0);
      nap(1'b0, 1'b1);
      ticks(3, 32, 0);
      chk("wfe asleep", 0, n);
      rouse();
      bus(1'b1, OFS_SYS_EN, 32'h1);
      ticks(2, 64, 0);
      chk("cop on", 8, n);
      nap(1'b1, 1'b0);
      ticks(2, 64, 0);
      chk("cop asleep", 0, n);
      ticks(4, 64, 0);
      chk("cop free", 8, n);
      rouse();
      ticks(2, 64, 0);
      chk("cop woken", 8, n);
      $display("sleep test done");
   endtask
   task finish_test();
      $display("checks %0d, mismatches %0d", num_checks, n_fail);
      if (n_fail == 0 && num_checks > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   // main sequence
   initial begin
      repeat (10) @(posedge ref_clk);
      reset_n <= 1'b1;
      @(posedge ref_clk);
      t_reset();
      t_div();
      t_ready();
      t_periph();
      t_usb();
      t_sleep();
      finish_test();
   end
endmodule // test_mpcg_top
